/* File: src/fcr_pkg.sv */
package fcr_pkg;
  // fault slots, lowest slot wins when several arrive together
  typedef enum int {
    F_OC1, F_OC2, F_PWR, F_THERMO, F_UVPWR, F_UVLOG, F_OFS, F_TNORSP,
    F_POVF, F_ZERO, F_CRC, F_READ, F_AMPL, F_FREQ, F_FOLL, F_VEL,
    F_ENA, F_MOTT, F_LIM, F_DUP, F_FUSE, F_JMP, F_LINE, F_REG, F_STK,
    F_CFGA, F_CFGB, F_NFLT
  } fcr_flt_e;
  // fault indication pins, each passes a two-stage synchroniser
  typedef enum int {
    P_THERMO, P_UVPWR, P_UVLOG, P_TNORSP, P_POVF, P_ZERO, P_CRC,
    P_READ, P_AMPL, P_FREQ, P_FUSE, P_NPIN
  } fcr_pin_e;
  localparam logic [7:0] FLT_CODE [F_NFLT] = '{
    8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0D, 8'h10,
    8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h1A, 8'h1D,
    8'h1E, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
  // register byte addresses
  localparam logic [7:0] A_CODE = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_ARM  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_OCTH = 8'h10;
  localparam logic [7:0] A_PWRL = 8'h14;
  localparam logic [7:0] A_MAXI = 8'h18;
  localparam logic [7:0] A_FOLL = 8'h1C;
  localparam logic [7:0] A_VELL = 8'h20;
  localparam logic [7:0] A_LIMC = 8'h24;
  localparam logic [7:0] A_ENAC = 8'h28;
  localparam logic [7:0] A_IFNC = 8'h2C;
  localparam logic [7:0] A_CSEL = 8'h30;
  localparam logic [7:0] A_CEDG = 8'h34;
  localparam logic [7:0] A_CFGA = 8'h38;
  localparam logic [7:0] A_CFGB = 8'h3C;
  localparam logic [7:0] A_CPOS = 8'h40;
  // field positions
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_ERR_BIT = 26;
  localparam int STAT_CAP_BIT = 30;
  localparam int LIMC_EN_BIT  = 0;
  localparam int IFNC_EN_BIT  = 3;
  localparam int CEDG_FALL_BIT = 0;
  localparam logic [31:0] ARM_VALUE = 32'h00000001;
  // reset values
  localparam logic [7:0]  RST_CODE = 8'h00;
  localparam logic [15:0] RST_OCTH = 16'hFFFF;
  localparam logic [31:0] RST_PWRL = 32'hFFFFFFFF;
  localparam logic [15:0] RST_MAXI = 16'hFFFF;
  localparam logic [31:0] RST_FOLL = 32'hFFFFFFFF;
  localparam logic [31:0] RST_VELL = 32'hFFFFFFFF;
  localparam logic [7:0]  RST_LIMC = 8'h00;
  localparam logic [7:0]  RST_ENAC = 8'h01;
  localparam logic [7:0]  RST_IFNC = 8'h00;
  localparam logic [7:0]  RST_CSEL = 8'h00;
  localparam logic [7:0]  RST_CEDG = 8'h00;
  localparam logic [7:0]  RST_CFG  = 8'h00;
  // limits
  localparam logic [23:0] OFS_PCT  = 24'h000008;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  localparam logic [15:0] JUMP_MAX = 16'h01FF;
  localparam logic [15:0] LINE_MAX = 16'h1FFE;
  localparam logic [8:0]  STK_DEPTH = 9'h100;
endpackage

/* File: src/fcr_top.sv */
// Operation
// - status bit 30 sets when the selected input edge captures position.
// - writing one to the capture arm register clears the capture flag.
// - fault code register reads 0 to 255, zero after reset.
// - phase one overcurrent gives code 2, phase two gives code 3.
// - power integral above its limit gives code 4.
// - board thermostat hot gives code 5, silent sensor gives 13.
// - power supply undervoltage gives 7, logic supply low gives 8.
// - current offset above 8 percent of max current gives code 10.
// - encoder serial CRC error gives 18, read failure gives 19.
// - encoder position overflow gives 16, zero not found gives 17.
// - low encoder amplitude gives 20, excess input frequency gives 21.
// - absolute following error above its limit gives code 23.
// - absolute velocity above its limit gives code 24.
// - power on with enable input low and check config zero gives 26.
// - selected motor over-temperature input active gives code 29.
// - limit switch hit while moving, not in searches, gives 30.
// - duplicate sequence label gives code 33.
// - encoder supply fuse failure gives code 35.
// - jump or call target label above 511 gives code 36.
// - executing a sequence line above 8190 gives code 37.
// - register index over maximum gives 38, stack past 256 gives 39.
// - invalid first checked config gives 40, second gives 41.
// - status bit 26 shows error mode while a code is pending.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module fcr_top #(
  parameter logic [15:0] JMAX  = fcr_pkg::JUMP_MAX,
  parameter logic [15:0] LMAX  = fcr_pkg::LINE_MAX,
  parameter logic [15:0] RMAX  = 16'h00FF,
  parameter logic [8:0]  SDEP  = fcr_pkg::STK_DEPTH,
  parameter logic [7:0]  CAMAX = 8'h03,
  parameter logic [7:0]  CBMAX = 8'h03
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  DIG_IN,
  input  wire logic [1:0]  LIMIT_SW,
  input  wire logic [fcr_pkg::P_NPIN-1:0] FAULT_PIN,
  input  wire logic [15:0] PHASE1_CURRENT,
  input  wire logic [15:0] PHASE2_CURRENT,
  input  wire logic [31:0] POWER_INTEGRAL,
  input  wire logic [15:0] CURRENT_OFFSET,
  input  wire logic [31:0] FOLLOW_ERR,
  input  wire logic [31:0] VELOCITY,
  input  wire logic [31:0] POSITION,
  input  wire logic        POWER_ON_REQ,
  input  wire logic        MOVING,
  input  wire logic        INDEX_SEARCH,
  input  wire logic        LIMIT_SEARCH,
  input  wire logic        LABEL_DUP,
  input  wire logic        JUMP_VALID,
  input  wire logic [15:0] JUMP_LABEL,
  input  wire logic        EXEC_VALID,
  input  wire logic [15:0] EXEC_LINE,
  input  wire logic        REG_ACCESS,
  input  wire logic [15:0] REG_INDEX,
  input  wire logic        STACK_PUSH,
  input  wire logic        STACK_POP,
  output logic      [7:0]  FAULT_CODE,
  output logic             ERROR_MODE,
  output logic             CAPTURE_DONE
);
  localparam int NS = fcr_pkg::P_NPIN + 10;
  localparam int NF = fcr_pkg::F_NFLT;

  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [fcr_pkg::P_NPIN-1:0] fpin;
  logic [7:0]    din;
  logic [1:0]    lim;
  logic [15:0]   oc_thr_q;
  logic [31:0]   pwr_lim_q;
  logic [15:0]   max_cur_q;
  logic [31:0]   fol_lim_q;
  logic [31:0]   vel_lim_q;
  logic [7:0]    lim_cfg_q;
  logic [7:0]    ena_chk_q;
  logic [7:0]    ifn_cfg_q;
  logic [7:0]    cap_sel_q;
  logic [7:0]    cap_edg_q;
  logic [7:0]    cfg_a_q;
  logic [7:0]    cfg_b_q;
  logic [7:0]    code_q;
  logic [8:0]    depth_q;
  logic          cap_q;
  logic          cap_prev_q;
  logic [1:0]    warm_q;
  logic [31:0]   cap_pos_q;
  logic [31:0]   prdata_q;
  logic          slverr_q;
  logic [NF-1:0] flt;
  logic [7:0]    first_code;
  logic          any_flt;
  logic          wr_en;
  logic          clr_wr;
  logic          arm_wr;
  logic          cap_src;
  logic          cap_edge;
  logic [31:0]   rd_mux;
  logic          rd_hit;
  logic [15:0]   abs1;
  logic [15:0]   abs2;
  logic [15:0]   abs_ofs;
  logic [31:0]   abs_fol;
  logic [31:0]   abs_vel;
  logic [23:0]   ofs_scaled;
  logic [23:0]   ofs_limit;

  function automatic logic [15:0] abs16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction

  // every pin passes two flops; only the second stage is read
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {LIMIT_SW, DIG_IN, FAULT_PIN};
      sync2_q <= sync1_q;
    end
  end

  assign fpin = sync2_q[fcr_pkg::P_NPIN-1:0];
  assign din  = sync2_q[fcr_pkg::P_NPIN+7:fcr_pkg::P_NPIN];
  assign lim  = sync2_q[NS-1:NS-2];

  // apb strobes; zero wait states, writes land in the access cycle
  assign wr_en  = PSEL & PENABLE & PWRITE;
  assign clr_wr = wr_en & (PADDR == fcr_pkg::A_CTRL)
                  & PWDATA[fcr_pkg::CTRL_CLR_BIT];
  assign arm_wr = wr_en & (PADDR == fcr_pkg::A_ARM)
                  & (PWDATA == fcr_pkg::ARM_VALUE);
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_q;
  assign PSLVERR = slverr_q & PSEL & PENABLE;

  // configuration registers written by software
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      oc_thr_q  <= fcr_pkg::RST_OCTH;
      pwr_lim_q <= fcr_pkg::RST_PWRL;
      max_cur_q <= fcr_pkg::RST_MAXI;
      fol_lim_q <= fcr_pkg::RST_FOLL;
      vel_lim_q <= fcr_pkg::RST_VELL;
      lim_cfg_q <= fcr_pkg::RST_LIMC;
      ena_chk_q <= fcr_pkg::RST_ENAC;
      ifn_cfg_q <= fcr_pkg::RST_IFNC;
      cap_sel_q <= fcr_pkg::RST_CSEL;
      cap_edg_q <= fcr_pkg::RST_CEDG;
      cfg_a_q   <= fcr_pkg::RST_CFG;
      cfg_b_q   <= fcr_pkg::RST_CFG;
    end else if (wr_en) begin
      case (PADDR)
        fcr_pkg::A_OCTH: oc_thr_q  <= PWDATA[15:0];
        fcr_pkg::A_PWRL: pwr_lim_q <= PWDATA;
        fcr_pkg::A_MAXI: max_cur_q <= PWDATA[15:0];
        fcr_pkg::A_FOLL: fol_lim_q <= PWDATA;
        fcr_pkg::A_VELL: vel_lim_q <= PWDATA;
        fcr_pkg::A_LIMC: lim_cfg_q <= PWDATA[7:0];
        fcr_pkg::A_ENAC: ena_chk_q <= PWDATA[7:0];
        fcr_pkg::A_IFNC: ifn_cfg_q <= PWDATA[7:0];
        fcr_pkg::A_CSEL: cap_sel_q <= PWDATA[7:0];
        fcr_pkg::A_CEDG: cap_edg_q <= PWDATA[7:0];
        fcr_pkg::A_CFGA: cfg_a_q   <= PWDATA[7:0];
        fcr_pkg::A_CFGB: cfg_b_q   <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets answer with slave error
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (PADDR)
      fcr_pkg::A_CODE: rd_mux[7:0] = code_q;
      fcr_pkg::A_CTRL: rd_mux = '0;
      fcr_pkg::A_ARM:  rd_mux = '0;
      fcr_pkg::A_STAT: begin
        rd_mux[fcr_pkg::STAT_ERR_BIT] = (code_q != '0);
        rd_mux[fcr_pkg::STAT_CAP_BIT] = cap_q;
      end
      fcr_pkg::A_OCTH: rd_mux[15:0] = oc_thr_q;
      fcr_pkg::A_PWRL: rd_mux = pwr_lim_q;
      fcr_pkg::A_MAXI: rd_mux[15:0] = max_cur_q;
      fcr_pkg::A_FOLL: rd_mux = fol_lim_q;
      fcr_pkg::A_VELL: rd_mux = vel_lim_q;
      fcr_pkg::A_LIMC: rd_mux[7:0] = lim_cfg_q;
      fcr_pkg::A_ENAC: rd_mux[7:0] = ena_chk_q;
      fcr_pkg::A_IFNC: rd_mux[7:0] = ifn_cfg_q;
      fcr_pkg::A_CSEL: rd_mux[7:0] = cap_sel_q;
      fcr_pkg::A_CEDG: rd_mux[7:0] = cap_edg_q;
      fcr_pkg::A_CFGA: rd_mux[7:0] = cfg_a_q;
      fcr_pkg::A_CFGB: rd_mux[7:0] = cfg_b_q;
      fcr_pkg::A_CPOS: rd_mux = cap_pos_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // read data is sampled in the setup cycle so it leaves a flop
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (PSEL & ~PENABLE) begin
      prdata_q <= PWRITE ? '0 : rd_mux;
      slverr_q <= ~rd_hit;
    end
  end

  // magnitudes: a negative reading trips the same limit as a positive one
  assign abs1       = abs16(PHASE1_CURRENT);
  assign abs2       = abs16(PHASE2_CURRENT);
  assign abs_ofs    = abs16(CURRENT_OFFSET);
  assign abs_fol    = abs32(FOLLOW_ERR);
  assign abs_vel    = abs32(VELOCITY);
  // offset*100 > max*8 avoids a divider
  assign ofs_scaled = {8'h00, abs_ofs} * fcr_pkg::PCT_FULL;
  assign ofs_limit  = {8'h00, max_cur_q} * fcr_pkg::OFS_PCT;

  // fault detection, one term per slot
  always_comb begin
    flt = '0;
    flt[fcr_pkg::F_OC1]    = abs1 > oc_thr_q;
    flt[fcr_pkg::F_OC2]    = abs2 > oc_thr_q;
    flt[fcr_pkg::F_PWR]    = POWER_INTEGRAL > pwr_lim_q;
    flt[fcr_pkg::F_THERMO] = fpin[fcr_pkg::P_THERMO];
    flt[fcr_pkg::F_TNORSP] = fpin[fcr_pkg::P_TNORSP];
    flt[fcr_pkg::F_UVPWR]  = fpin[fcr_pkg::P_UVPWR];
    flt[fcr_pkg::F_UVLOG]  = fpin[fcr_pkg::P_UVLOG];
    flt[fcr_pkg::F_OFS]    = ofs_scaled > ofs_limit;
    flt[fcr_pkg::F_CRC]    = fpin[fcr_pkg::P_CRC];
    flt[fcr_pkg::F_READ]   = fpin[fcr_pkg::P_READ];
    flt[fcr_pkg::F_POVF]   = fpin[fcr_pkg::P_POVF];
    flt[fcr_pkg::F_ZERO]   = fpin[fcr_pkg::P_ZERO];
    flt[fcr_pkg::F_AMPL]   = fpin[fcr_pkg::P_AMPL];
    flt[fcr_pkg::F_FREQ]   = fpin[fcr_pkg::P_FREQ];
    flt[fcr_pkg::F_FOLL]   = abs_fol > fol_lim_q;
    flt[fcr_pkg::F_VEL]    = abs_vel > vel_lim_q;
    flt[fcr_pkg::F_ENA]    = POWER_ON_REQ & ~din[0]
                             & (ena_chk_q == '0);
    flt[fcr_pkg::F_MOTT]   = ifn_cfg_q[fcr_pkg::IFNC_EN_BIT]
                             & din[ifn_cfg_q[2:0]];
    flt[fcr_pkg::F_LIM]    = lim_cfg_q[fcr_pkg::LIMC_EN_BIT] & MOVING
                             & ~INDEX_SEARCH & ~LIMIT_SEARCH
                             & (|lim);
    flt[fcr_pkg::F_DUP]    = LABEL_DUP;
    flt[fcr_pkg::F_FUSE]   = fpin[fcr_pkg::P_FUSE];
    flt[fcr_pkg::F_JMP]    = JUMP_VALID & (JUMP_LABEL > JMAX);
    flt[fcr_pkg::F_LINE]   = EXEC_VALID & (EXEC_LINE > LMAX);
    flt[fcr_pkg::F_REG]    = REG_ACCESS & (REG_INDEX > RMAX);
    flt[fcr_pkg::F_STK]    = STACK_PUSH & ~STACK_POP
                             & (depth_q == SDEP);
    flt[fcr_pkg::F_CFGA]   = cfg_a_q > CAMAX;
    flt[fcr_pkg::F_CFGB]   = cfg_b_q > CBMAX;
  end

  // lowest slot wins so simultaneous faults report the smallest code
  always_comb begin
    first_code = '0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (flt[i]) begin
        first_code = fcr_pkg::FLT_CODE[i];
      end
    end
  end

  assign any_flt = |flt;

  // call stack depth; an overflowing push is refused, not counted
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      depth_q <= '0;
    end else if (STACK_PUSH & ~STACK_POP & (depth_q != SDEP)) begin
      depth_q <= depth_q + 9'h001;
    end else if (STACK_POP & ~STACK_PUSH & (depth_q != '0)) begin
      depth_q <= depth_q - 9'h001;
    end
  end

  // first code holds; a fault in the clear cycle re-latches at once
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      code_q <= fcr_pkg::RST_CODE;
    end else if ((code_q == '0) | clr_wr) begin
      code_q <= any_flt ? first_code : '0;
    end
  end

  // capture waits until both sync stages and the previous-value flop hold
  // real samples, so a pin already high at reset does not look like an edge
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      warm_q <= '0;
    end else if (warm_q != '1) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  // position capture on the chosen edge of the chosen input
  assign cap_src  = din[cap_sel_q[2:0]];
  assign cap_edge = (&warm_q)
                    & (cap_edg_q[fcr_pkg::CEDG_FALL_BIT]
                       ? (cap_prev_q & ~cap_src)
                       : (~cap_prev_q & cap_src));

  // flag set beats the rearm write so no edge is lost
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cap_prev_q <= 1'b0;
      cap_q      <= 1'b0;
      cap_pos_q  <= '0;
    end else begin
      cap_prev_q <= cap_src;
      if (cap_edge) begin
        cap_q <= 1'b1;
      end else if (arm_wr) begin
        cap_q <= 1'b0;
      end
      if (cap_edge & (~cap_q | arm_wr)) begin
        cap_pos_q <= POSITION;
      end
    end
  end

  assign FAULT_CODE   = code_q;
  assign ERROR_MODE   = (code_q != '0);
  assign CAPTURE_DONE = cap_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence arm_write_s;
    PSEL && PENABLE && PWRITE && PADDR == fcr_pkg::A_ARM
      && PWDATA == 32'h00000001;
  endsequence

  sequence cap_edge_s;
    cap_edge;
  endsequence

  cap_set_a: assert property (cap_edge_s |=> CAPTURE_DONE)
    else $error("capture flag not set after input edge");
  cap_clear_a: assert property (arm_write_s and !cap_edge
      |=> !CAPTURE_DONE)
    else $error("capture flag not cleared by arm write");
  cap_hold_a: assert property (CAPTURE_DONE && !arm_wr
      |=> CAPTURE_DONE)
    else $error("capture flag dropped without arm write");
  code_idle_a: assert property (FAULT_CODE == 8'h00
      && !any_flt |=> FAULT_CODE == 8'h00)
    else $error("code changed with no fault");
  oc_code_a: assert property (FAULT_CODE == 8'h00
      && $countones(flt) == 1 && abs2 > oc_thr_q |=> FAULT_CODE == 8'h03)
    else $error("phase two overcurrent not reported as 3");
  vel_code_a: assert property (FAULT_CODE == 8'h00
      && $countones(flt) == 1 && abs_vel > vel_lim_q
      |=> FAULT_CODE == 8'h18)
    else $error("overspeed not reported as 24");
  limit_code_a: assert property (FAULT_CODE == 8'h00
      && $countones(flt) == 1 && lim_cfg_q[0] && MOVING
      && !INDEX_SEARCH && !LIMIT_SEARCH && lim != 2'b00
      |=> FAULT_CODE == 8'h1E)
    else $error("limit switch not reported as 30");
  jump_code_a: assert property (FAULT_CODE == 8'h00
      && $countones(flt) == 1 && JUMP_VALID && JUMP_LABEL > 16'h01FF
      |=> FAULT_CODE == 8'h24)
    else $error("bad jump label not reported as 36");
  stack_code_a: assert property (FAULT_CODE == 8'h00
      && $countones(flt) == 1 && STACK_PUSH && !STACK_POP
      && depth_q == 9'h100 |=> FAULT_CODE == 8'h27)
    else $error("stack overflow not reported as 39");
  err_stat_a: assert property (PSEL && !PENABLE
      && !PWRITE && PADDR == fcr_pkg::A_STAT
      |=> PRDATA[26] == $past(FAULT_CODE != 8'h00))
    else $error("error mode bit disagrees with code");
  code_latch_a: assert property (FAULT_CODE == 8'h00
      && any_flt |=> FAULT_CODE == $past(first_code))
    else $error("first fault code not latched");
  code_hold_a: assert property (FAULT_CODE != 8'h00
      && !clr_wr |=> $stable(FAULT_CODE))
    else $error("latched code changed without clear");
endmodule

/* File: bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, ERROR_MODE, CAPTURE_DONE;
  logic [7:0]  DIG_IN = 8'h01, FAULT_CODE;
  logic [1:0]  LIMIT_SW = 2'h0;
  logic [10:0] FAULT_PIN = '0;
  logic [15:0] PHASE1_CURRENT = '0, PHASE2_CURRENT = '0, CURRENT_OFFSET = '0;
  logic [31:0] POWER_INTEGRAL = '0, FOLLOW_ERR = '0, VELOCITY = '0;
  logic [31:0] POSITION = '0, pos_a;
  logic        POWER_ON_REQ = 0, MOVING = 0, INDEX_SEARCH = 0;
  logic        LIMIT_SEARCH = 0, LABEL_DUP = 0, JUMP_VALID = 0;
  logic        EXEC_VALID = 0, REG_ACCESS = 0, STACK_PUSH = 0, STACK_POP = 0;
  logic [15:0] JUMP_LABEL = '0, EXEC_LINE = '0, REG_INDEX = '0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          n_mismatch = 0, n_compared = 0;
  integer      seed = 32'hc85322fe;

  fcr_top dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIG_IN(DIG_IN),
    .LIMIT_SW(LIMIT_SW), .FAULT_PIN(FAULT_PIN),
    .PHASE1_CURRENT(PHASE1_CURRENT), .PHASE2_CURRENT(PHASE2_CURRENT),
    .POWER_INTEGRAL(POWER_INTEGRAL), .CURRENT_OFFSET(CURRENT_OFFSET),
    .FOLLOW_ERR(FOLLOW_ERR), .VELOCITY(VELOCITY), .POSITION(POSITION),
    .POWER_ON_REQ(POWER_ON_REQ), .MOVING(MOVING),
    .INDEX_SEARCH(INDEX_SEARCH), .LIMIT_SEARCH(LIMIT_SEARCH),
    .LABEL_DUP(LABEL_DUP), .JUMP_VALID(JUMP_VALID), .JUMP_LABEL(JUMP_LABEL),
    .EXEC_VALID(EXEC_VALID), .EXEC_LINE(EXEC_LINE),
    .REG_ACCESS(REG_ACCESS), .REG_INDEX(REG_INDEX), .STACK_PUSH(STACK_PUSH),
    .STACK_POP(STACK_POP), .FAULT_CODE(FAULT_CODE),
    .ERROR_MODE(ERROR_MODE), .CAPTURE_DONE(CAPTURE_DONE));

  // free running 100 MHz clock
  always #5 REF_CLK = ~REF_CLK;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // note the expected answer first, then run one transfer
  task automatic apb(input bit wr, input logic [7:0] a,
                     input logic [31:0] d, ed, input bit ee);
    exp_q.push_back({wr, ee, ed});
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // answers are judged at the completing edge, oldest note first
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, PSLVERR}, {31'h0, e[32]});
      if (!e[33]) chk("prdata", PRDATA, e[31:0]);
    end
  end

  // every input-driven fault source back to its quiet level; config registers and stack depth stay as they are
  task automatic quiet();
    @(posedge REF_CLK);
    {PHASE1_CURRENT, PHASE2_CURRENT, CURRENT_OFFSET} <= '0;
    {POWER_INTEGRAL, FOLLOW_ERR, VELOCITY} <= '0;
    {POWER_ON_REQ, MOVING, INDEX_SEARCH, LABEL_DUP} <= '0;
    {JUMP_VALID, EXEC_VALID, REG_ACCESS} <= '0;
    DIG_IN <= 8'h01;
    LIMIT_SW <= 2'h0;
    FAULT_PIN <= '0;
  endtask

  // v=0 puts the cause right at its limit, v=1 just beyond it
  task automatic set_cond(input int i, input bit v);
    if (i == fcr_pkg::F_CFGA || i == fcr_pkg::F_CFGB)
      apb(1, i == fcr_pkg::F_CFGA ? fcr_pkg::A_CFGA : fcr_pkg::A_CFGB,
          v ? 32'h4 : 32'h3, 0, 0);
    else if (i == fcr_pkg::F_STK) begin
      @(posedge REF_CLK);
      STACK_PUSH <= 1'b1;
      repeat (v ? 1 : 256) @(posedge REF_CLK);
      STACK_PUSH <= 1'b0;
    end else begin
      @(posedge REF_CLK);
      case (i)
        fcr_pkg::F_OC1: PHASE1_CURRENT <= v ? 16'hFF9B : 16'h0064;
        fcr_pkg::F_OC2: PHASE2_CURRENT <= v ? 16'h0065 : 16'hFF9C;
        fcr_pkg::F_PWR: POWER_INTEGRAL <= v ? 32'h3E9 : 32'h3E8;
        fcr_pkg::F_OFS: CURRENT_OFFSET <= v ? 16'hFFAF : 16'h0050;
        fcr_pkg::F_FOLL: FOLLOW_ERR <= v ? 32'hFFFFFE0B : 32'h1F4;
        fcr_pkg::F_VEL: VELOCITY <= v ? 32'h1F5 : 32'hFFFFFE0C;
        fcr_pkg::F_ENA: begin
          POWER_ON_REQ <= 1'b1;
          DIG_IN <= v ? 8'h00 : 8'h01;
        end
        fcr_pkg::F_MOTT: DIG_IN <= v ? 8'h09 : 8'h11;
        fcr_pkg::F_LIM: begin
          MOVING <= 1'b1;
          LIMIT_SW <= 2'h2;
          INDEX_SEARCH <= !v;
        end
        fcr_pkg::F_DUP: LABEL_DUP <= v;
        fcr_pkg::F_JMP: {JUMP_VALID, JUMP_LABEL} <= v ? 17'h10200 : 17'h101FF;
        fcr_pkg::F_LINE: {EXEC_VALID, EXEC_LINE} <= v ? 17'h11FFF : 17'h11FFE;
        fcr_pkg::F_REG: {REG_ACCESS, REG_INDEX} <= v ? 17'h10100 : 17'h100FF;
        fcr_pkg::F_FUSE: FAULT_PIN[10] <= v;
        default: FAULT_PIN[i < 6 ? i - 3 : i - 4] <= v;
      endcase
    end
  endtask

  // bounded wait for a latched code, pins need their sync stages
  task automatic wait_code();
    for (int k = 0; k < 20 && FAULT_CODE === 8'h00; k++) @(posedge REF_CLK);
    @(posedge REF_CLK);
    #1;
  endtask

  task automatic clear_fault();
    apb(1, fcr_pkg::A_CTRL, 32'h1, 0, 0);
    apb(0, fcr_pkg::A_CODE, 0, 32'h0, 0);
  endtask

  // watchdog sized well past the expected run length
  initial begin
    repeat (60000) @(posedge REF_CLK);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    // reset values, unmapped and read-only places
    apb(0, fcr_pkg::A_CODE, 0, 32'h0, 0);
    apb(0, fcr_pkg::A_OCTH, 0, 32'hFFFF, 0);
    apb(0, fcr_pkg::A_ENAC, 0, 32'h1, 0);
    apb(0, 8'h80, 0, 32'h0, 1);
    apb(1, 8'h80, 32'h5, 0, 1);
    apb(1, fcr_pkg::A_CODE, 32'h55, 0, 0);
    apb(0, fcr_pkg::A_CODE, 0, 32'h0, 0);
    // small limits so each cause can sit on its boundary
    apb(1, fcr_pkg::A_OCTH, 32'h64, 0, 0);
    apb(1, fcr_pkg::A_PWRL, 32'h3E8, 0, 0);
    apb(1, fcr_pkg::A_MAXI, 32'h3E8, 0, 0);
    apb(1, fcr_pkg::A_FOLL, 32'h1F4, 0, 0);
    apb(1, fcr_pkg::A_VELL, 32'h1F4, 0, 0);
    apb(1, fcr_pkg::A_LIMC, 32'h1, 0, 0);
    apb(1, fcr_pkg::A_ENAC, 32'h0, 0, 0);
    apb(1, fcr_pkg::A_IFNC, 32'hB, 0, 0);
    // capture watches input 7, which the fault loop never toggles
    apb(1, fcr_pkg::A_CSEL, 32'h7, 0, 0);
    for (int i = 0; i < fcr_pkg::F_NFLT; i++) begin
      set_cond(i, 0);
      repeat (4) @(posedge REF_CLK);
      #1 chk("code_at_limit", {24'h0, FAULT_CODE}, 0);
      set_cond(i, 1);
      wait_code();
      chk("code", {24'h0, FAULT_CODE}, {24'h0, fcr_pkg::FLT_CODE[i]});
      chk("error_mode", {31'h0, ERROR_MODE}, 1);
      apb(0, fcr_pkg::A_STAT, 0, 32'h04000000, 0);
      quiet();
      if (i == fcr_pkg::F_CFGA || i == fcr_pkg::F_CFGB)
        set_cond(i, 0);
      clear_fault();
    end
    // first code holds, later causes are ignored
    set_cond(fcr_pkg::F_VEL, 1);
    wait_code();
    set_cond(fcr_pkg::F_OC1, 1);
    repeat (3) @(posedge REF_CLK);
    #1 chk("held_code", {24'h0, FAULT_CODE}, 32'h18);
    quiet();
    clear_fault();
    // simultaneous causes, the smallest code wins
    @(posedge REF_CLK);
    VELOCITY <= 32'h1F5 + ($random(seed) & 32'hFF);
    PHASE2_CURRENT <= 16'h0200;
    wait_code();
    chk("priority", {24'h0, FAULT_CODE}, 32'h3);
    quiet();
    clear_fault();
    apb(0, fcr_pkg::A_STAT, 0, 32'h0, 0);
    // stack is full here; one pop leaves room for exactly one push
    @(posedge REF_CLK);
    STACK_POP <= 1'b1;
    @(posedge REF_CLK);
    {STACK_POP, STACK_PUSH} <= 2'b01;
    @(posedge REF_CLK);
    STACK_PUSH <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 chk("stack_room", {24'h0, FAULT_CODE}, 0);
    set_cond(fcr_pkg::F_STK, 1);
    wait_code();
    chk("stack_full", {24'h0, FAULT_CODE}, 32'h27);
    quiet();
    clear_fault();
    // rising edge on input 2 captures the position
    apb(1, fcr_pkg::A_CSEL, 32'h2, 0, 0);
    pos_a = $random(seed);
    POSITION <= pos_a;
    DIG_IN <= 8'h05;
    for (int k = 0; k < 20 && CAPTURE_DONE !== 1'b1; k++) @(posedge REF_CLK);
    #1 chk("capture_done", {31'h0, CAPTURE_DONE}, 1);
    POSITION <= $random(seed);
    apb(0, fcr_pkg::A_STAT, 0, 32'h40000000, 0);
    apb(0, fcr_pkg::A_CPOS, 0, pos_a, 0);
    apb(1, fcr_pkg::A_ARM, 32'h2, 0, 0);
    #1 chk("arm_wrong", {31'h0, CAPTURE_DONE}, 1);
    apb(1, fcr_pkg::A_ARM, fcr_pkg::ARM_VALUE, 0, 0);
    #1 chk("arm_clear", {31'h0, CAPTURE_DONE}, 0);
    // falling edge selected, rearmed capture takes a new position
    apb(1, fcr_pkg::A_CEDG, 32'h1, 0, 0);
    pos_a = $random(seed);
    POSITION <= pos_a;
    DIG_IN <= 8'h01;
    for (int k = 0; k < 20 && CAPTURE_DONE !== 1'b1; k++) @(posedge REF_CLK);
    #1 chk("capture_fall", {31'h0, CAPTURE_DONE}, 1);
    apb(0, fcr_pkg::A_CPOS, 0, pos_a, 0);
    repeat (4) @(posedge REF_CLK);
    final_report();
  end
endmodule
